/* File: rpm_defs.svh */
`ifndef RPM_DEFS_SVH
`define RPM_DEFS_SVH

// ==========================================================================
// Register byte offsets on the APB word grid.
`define RPM_OFS_SYS_CTRL 12'h000
`define RPM_OFS_RESET_CAUSE 12'h004
`define RPM_OFS_WDOG 12'h008
`define RPM_OFS_MODE_STAT 12'h00C

// ==========================================================================
// Field positions.
`define RPM_BIT_SLEEP_UNLOCK 7
`define RPM_BIT_PCONF_EN 6
`define RPM_BIT_BUS_EN 5
`define RPM_BIT_WD_EN 4
`define RPM_BIT_SLEEP_REQ 7
`define RPM_CAUSE_LSB 1
`define RPM_CAUSE_WIDTH 5
`define RPM_BIT_SLEEP_HIST 0
`define RPM_MODE_LSB 1

// ==========================================================================
// Reset values, watchdog keys and limit.
`define RPM_CTRL_BIT_RST 1'b0
`define RPM_CAUSE_RST 5'h00
`define RPM_WD_COUNT_RST 4'h0
`define RPM_WD_KEY_ARM 4'hA
`define RPM_WD_KEY_FIRE 4'h3
`define RPM_WD_LIMIT 4'h8

`endif

/* File: rpm_pkg.sv */
package rpm_pkg;

    // ======================================================================
    // Operating modes.
    typedef enum logic [1:0] {
        rpm_mode_active = 2'b00,
        rpm_mode_standby = 2'b01,
        rpm_mode_sleep = 2'b10
    } rpm_mode_t;

endpackage

/* File: rpm_wd_if.sv */
`timescale 1ns/10ps
interface rpm_wd_if;
    logic key_write;
    logic [3:0] key_data;
    logic run;
    logic tick;
    logic [3:0] count;
    logic timeout;

    modport ctrl (output key_write, output key_data, output run, output tick,
                  input count, input timeout);
    modport wdog (input key_write, input key_data, input run, input tick,
                  output count, output timeout);
endinterface

/* File: rpm_watchdog.sv */
`timescale 1ns/10ps
`include "rpm_defs.svh"
module rpm_watchdog import rpm_pkg::*; (
    input wire logic ref_clk,
    input wire logic cold_clear,
    rpm_wd_if.wdog wd
);
    logic armed_reg;
    logic [3:0] count_reg;

    // ======================================================================
    // Key sequence.
    // [R23] Arm then fire.
    always_ff @(posedge ref_clk) begin
        if (cold_clear) begin
            armed_reg <= 1'b0;
        end else if (wd.key_write) begin
            armed_reg <= (wd.key_data == `RPM_WD_KEY_ARM);
        end
    end

    // ======================================================================
    // Counter. A valid clear beats a tick in the same cycle.
    // [R15] Cold clears count.
    always_ff @(posedge ref_clk) begin
        if (cold_clear) begin
            count_reg <= `RPM_WD_COUNT_RST;
        end else if (wd.key_write && armed_reg && wd.key_data == `RPM_WD_KEY_FIRE) begin
            count_reg <= `RPM_WD_COUNT_RST;
        end else if (count_reg == `RPM_WD_LIMIT) begin
            count_reg <= `RPM_WD_COUNT_RST;
        end else if (wd.run && wd.tick) begin
            count_reg <= 4'(count_reg + 4'h1);
        end
    end

    assign wd.count = count_reg;
    // [R24] Timeout at eight.
    assign wd.timeout = (count_reg == `RPM_WD_LIMIT);
endmodule

/* File: rpm_reset_dist.sv */
`timescale 1ns/10ps
module rpm_reset_dist (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic cold_src,
    input wire logic other_src,
    input wire logic pconf_en,
    input wire logic asleep,
    output logic reset_cold,
    output logic reset_system,
    output logic reset_pconf,
    output logic reset_sleep
);
    // ======================================================================
    // Registered so that all four resets release on the same edge.
    // [R25] Synchronous outputs.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            reset_cold <= 1'b1;
            reset_system <= 1'b1;
            reset_pconf <= 1'b1;
            reset_sleep <= 1'b1;
        end else begin
            // [R18] Cold from POR/pin.
            reset_cold <= cold_src;
            // [R19] System from any source.
            reset_system <= cold_src | other_src;
            // [R20] Pconf gated by enable.
            reset_pconf <= cold_src | (other_src & pconf_en);
            // [R21] Sleep reset sources.
            reset_sleep <= cold_src | asleep;
        end
    end
endmodule

/* File: rpm_manager.sv */
// Function
// [R1] Power-on clears all bits, forces RC on, crystal off, holds CPU reset.
// [R2] Other resets clear system bits, pconf bits if enabled, reset CPU.
// [R3] Active mode lets processor and peripherals run.
// [R4] Halt stops CPU only; reset or enabled wake request ends standby.
// [R5] Sleep stops all clocks and peripherals; no time keeping.
// [R6] Sleep needs unlock bit first, then a separate sleep-request write.
// [R7] Sleep ends only on power-on, reset pin or port combination.
// [R8] Port combination wake keeps every cold-reset bit.
// [R9] Sleep history flag reads one after any sleep since cleared.
// [R10] Software places a no-operation after the sleep-entry write.
// [R11] Control bits 7..4: unlock, pconf, bus fault, watchdog; 3..0 zero.
// [R12] Watchdog enable cannot be cleared by software once set.
// [R13] Sleep request reads zero, cleared by system reset; bits 6,0 zero.
// [R14] Five cause flags in bits 5..1, cleared on read and cold reset; code clears them on any access and on power-on only, not the pin.
// [R15] Watchdog register: key written, count read, upper bits zero.
// [R16] Five reset sources plus software sleep request.
// [R17] Enabled bus fault causes a system reset.
// [R18] Cold reset from power-on and reset pin only.
// [R19] System reset from cold or any enabled source, never sleep.
// [R20] Pconf reset follows system reset when enabled; always on cold.
// [R21] Sleep reset during sleep and on power-on or reset pin.
// [R22] Sleep request asserts only the sleep reset.
// [R23] Key 0x0A then 0x03 clears watchdog; other writes cancel.
// [R24] Enabled watchdog resets the system when count reaches eight.
// [R25] Cause flags and resets are synchronous to the clock.
//
// The register offsets and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/10ps
`include "rpm_defs.svh"
module rpm_manager import rpm_pkg::*; #(
    parameter int ADDR_WIDTH = 12
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_WIDTH-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic por_src,
    input wire logic reset_pin,
    input wire logic port_combination_reset,
    input wire logic cpu_bus_fault,
    input wire logic wdog_tick,
    input wire logic cpu_halt,
    input wire logic wake_request,
    output logic reset_cold,
    output logic reset_system,
    output logic reset_pconf,
    output logic reset_sleep,
    output logic cpu_run,
    output logic periph_clock_enable,
    output logic osc_default_force,
    output logic [1:0] operating_mode
);
    // ======================================================================
    // Declarations.
    rpm_mode_t mode_reg;
    rpm_mode_t mode_next;
    logic sleep_unlock_reg;
    logic port_cfg_reset_enable_reg;
    logic bus_fault_reset_enable_reg;
    logic watchdog_reset_enable_reg;
    logic sleep_request_reg;
    logic sleep_history_flag_reg;
    logic [`RPM_CAUSE_WIDTH-1:0] cause_reg;
    logic [`RPM_CAUSE_WIDTH-1:0] cause_set;
    logic [31:0] prdata_reg;
    logic [31:0] rd_word;
    logic setup_phase;
    logic access_phase;
    logic hit_ctrl;
    logic hit_cause;
    logic hit_wdog;
    logic hit_stat;
    logic mapped;
    logic wr_ctrl;
    logic wr_cause;
    logic wr_stat;
    logic cause_access;
    logic cold_clear;
    logic por_clear;
    logic asleep;
    logic wd_fire;
    logic bus_fire;
    logic other_src;
    logic wake_src;
    logic [ADDR_WIDTH-1:0] ofs_ctrl;
    logic [ADDR_WIDTH-1:0] ofs_cause;
    logic [ADDR_WIDTH-1:0] ofs_wdog;
    logic [ADDR_WIDTH-1:0] ofs_stat;

    rpm_wd_if wd ();

    // ======================================================================
    // Reset sources.
    // The pin is a cold source here, so control and watchdog bits fall
    // with it; cause flags only fall with power-on so the pin flags survive.
    // [R18] Cold source set.
    assign cold_clear = rst | por_src | reset_pin;
    assign por_clear = rst | por_src;
    // [R21] Sleep decode.
    assign asleep = (mode_reg == rpm_mode_sleep);

    // Watchdog and bus fault have no clock in sleep and must not wake it.
    // [R24] Enabled watchdog source.
    assign wd_fire = wd.timeout & watchdog_reset_enable_reg & ~asleep;
    // [R17] Enabled bus fault.
    assign bus_fire = cpu_bus_fault & bus_fault_reset_enable_reg & ~asleep;
    // [R16] Non-cold sources combined.
    assign other_src = port_combination_reset | wd_fire | bus_fire;
    // [R7] Only three wake events.
    assign wake_src = por_src | reset_pin | port_combination_reset;

    // The distributor registers every reset so that they all drop on one edge.
    // [R19] System from all sources.
    // [R20] Pconf gated by enable.
    // [R21] Sleep reset while asleep.
    // [R22] Sleep request only via asleep.
    rpm_reset_dist u_dist (
        .ref_clk(ref_clk),
        .rst(rst),
        .cold_src(por_src | reset_pin),
        .other_src(other_src),
        .pconf_en(port_cfg_reset_enable_reg),
        .asleep(asleep),
        .reset_cold(reset_cold),
        .reset_system(reset_system),
        .reset_pconf(reset_pconf),
        .reset_sleep(reset_sleep)
    );

    // ======================================================================
    // Watchdog.
    // [R23] Key writes forwarded.
    assign wd.key_write = access_phase & pwrite & hit_wdog;
    assign wd.key_data = pwdata[3:0];
    // [R24] Counts once enabled.
    // [R5] No counting in sleep.
    assign wd.run = watchdog_reset_enable_reg & ~asleep;
    assign wd.tick = wdog_tick;

    // [R15] Count and key.
    rpm_watchdog u_wdog (
        .ref_clk(ref_clk),
        .cold_clear(cold_clear),
        .wd(wd.wdog)
    );

    // ======================================================================
    // APB decode.
    assign ofs_ctrl = ADDR_WIDTH'(`RPM_OFS_SYS_CTRL);
    assign ofs_cause = ADDR_WIDTH'(`RPM_OFS_RESET_CAUSE);
    assign ofs_wdog = ADDR_WIDTH'(`RPM_OFS_WDOG);
    assign ofs_stat = ADDR_WIDTH'(`RPM_OFS_MODE_STAT);
    assign setup_phase = psel & ~penable;
    assign access_phase = psel & penable;
    assign hit_ctrl = (paddr == ofs_ctrl);
    assign hit_cause = (paddr == ofs_cause);
    assign hit_wdog = (paddr == ofs_wdog);
    assign hit_stat = (paddr == ofs_stat);
    assign mapped = hit_ctrl | hit_cause | hit_wdog | hit_stat;
    assign wr_ctrl = access_phase & pwrite & hit_ctrl;
    assign wr_cause = access_phase & pwrite & hit_cause;
    assign wr_stat = access_phase & pwrite & hit_stat;
    assign cause_access = access_phase & hit_cause;

    // Zero wait states; unmapped accesses are flagged and have no effect.
    // An unmapped register access is only answered with an error here; the
    // core's own out-of-map accesses arrive on the bus fault input instead.
    assign pready = 1'b1;
    assign pslverr = access_phase & ~mapped;

    // ======================================================================
    // System control register.
    // [R11] Cold-only control bits.
    always_ff @(posedge ref_clk) begin
        if (cold_clear) begin
            sleep_unlock_reg <= `RPM_CTRL_BIT_RST;
            port_cfg_reset_enable_reg <= `RPM_CTRL_BIT_RST;
            bus_fault_reset_enable_reg <= `RPM_CTRL_BIT_RST;
        end else if (wr_ctrl) begin
            sleep_unlock_reg <= pwdata[`RPM_BIT_SLEEP_UNLOCK];
            port_cfg_reset_enable_reg <= pwdata[`RPM_BIT_PCONF_EN];
            bus_fault_reset_enable_reg <= pwdata[`RPM_BIT_BUS_EN];
        end
    end

    // [R12] Enable is set-only.
    always_ff @(posedge ref_clk) begin
        if (cold_clear) begin
            watchdog_reset_enable_reg <= `RPM_CTRL_BIT_RST;
        end else if (wr_ctrl && pwdata[`RPM_BIT_WD_EN]) begin
            watchdog_reset_enable_reg <= 1'b1;
        end
    end

    // ======================================================================
    // Sleep request.
    // The request is consumed one edge after the mode enters sleep. A write while
    // locked is dropped, so a stray write cannot put the chip to sleep.
    // A request that meets a system reset in the same cycle is lost, so
    // software must repeat it once the reset has passed.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            sleep_request_reg <= 1'b0;
        // [R13] System reset clears it.
        end else if (reset_system || asleep) begin
            sleep_request_reg <= 1'b0;
        // [R6] Unlock must precede request.
        end else if (wr_cause && pwdata[`RPM_BIT_SLEEP_REQ] && sleep_unlock_reg) begin
            sleep_request_reg <= 1'b1;
        end
    end

    // ======================================================================
    // Operating mode.
    // A halt and a sleep request in one cycle resolve to sleep.
    always_comb begin
        mode_next = mode_reg;
        unique case (mode_reg)
            rpm_mode_active: begin
                if (sleep_request_reg) begin
                    mode_next = rpm_mode_sleep;
                // [R4] Halt enters standby.
                end else if (cpu_halt && !reset_system) begin
                    mode_next = rpm_mode_standby;
                end
            end
            rpm_mode_standby: begin
                // [R4] Reset or wake ends standby.
                if (reset_system || wake_request) begin
                    mode_next = rpm_mode_active;
                end
            end
            rpm_mode_sleep: begin
                // [R7] Leave sleep on wake events.
                if (wake_src) begin
                    mode_next = rpm_mode_active;
                end
            end
            default: begin
                mode_next = rpm_mode_active;
            end
        endcase
    end

    // [R1] Power-up in active.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            mode_reg <= rpm_mode_active;
        end else begin
            mode_reg <= mode_next;
        end
    end

    // ======================================================================
    // Sleep history flag, cleared by writing one; a set wins the clear.
    // [R9] History of sleep.
    always_ff @(posedge ref_clk) begin
        if (por_clear) begin
            sleep_history_flag_reg <= 1'b0;
        end else if (asleep) begin
            sleep_history_flag_reg <= 1'b1;
        end else if (wr_stat && pwdata[`RPM_BIT_SLEEP_HIST]) begin
            sleep_history_flag_reg <= 1'b0;
        end
    end

    // ======================================================================
    // Reset cause flags, low index first: pin asleep, pin, port, dog, bus.
    // [R14] Cause flag sources.
    assign cause_set[0] = reset_pin & asleep;
    assign cause_set[1] = reset_pin;
    assign cause_set[2] = port_combination_reset;
    assign cause_set[3] = wd_fire;
    assign cause_set[4] = bus_fire;

    // Any access clears, so read and write clears share one path.
    genvar gi;
    generate
        for (gi = 0; gi < `RPM_CAUSE_WIDTH; gi++) begin : g_cause
            // [R8] Port wake keeps flags.
            always_ff @(posedge ref_clk) begin
                if (por_clear) begin
                    cause_reg[gi] <= 1'(`RPM_CAUSE_RST >> gi);
                // [R14] Set wins over clear.
                end else if (cause_set[gi]) begin
                    cause_reg[gi] <= 1'b1;
                end else if (cause_access) begin
                    cause_reg[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    // ======================================================================
    // Read path, captured in the setup phase.
    // Capturing before the access edge means a read that clears the cause
    // flags still returns them as they stood.
    always_comb begin
        rd_word = 32'h0000_0000;
        if (hit_ctrl) begin
            // [R11] Low nibble reads zero.
            rd_word[`RPM_BIT_SLEEP_UNLOCK] = sleep_unlock_reg;
            rd_word[`RPM_BIT_PCONF_EN] = port_cfg_reset_enable_reg;
            rd_word[`RPM_BIT_BUS_EN] = bus_fault_reset_enable_reg;
            rd_word[`RPM_BIT_WD_EN] = watchdog_reset_enable_reg;
        end else if (hit_cause) begin
            // [R13] Request bit reads zero.
            // [R14] Cause flags 5..1.
            rd_word[`RPM_CAUSE_LSB +: `RPM_CAUSE_WIDTH] = cause_reg;
        end else if (hit_wdog) begin
            // [R15] Count in low nibble.
            rd_word[3:0] = wd.count;
        end else if (hit_stat) begin
            // [R9] History and mode.
            rd_word[`RPM_BIT_SLEEP_HIST] = sleep_history_flag_reg;
            rd_word[`RPM_MODE_LSB +: 2] = mode_reg;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            prdata_reg <= 32'h0000_0000;
        end else if (setup_phase && !pwrite) begin
            prdata_reg <= rd_word;
        end
    end

    assign prdata = prdata_reg;

    // ======================================================================
    // Clock and core control.
    // [R3] Run only when active.
    // [R2] CPU held through system reset.
    assign cpu_run = (mode_reg == rpm_mode_active) & ~reset_system;
    // [R5] Sleep stops peripheral clocks.
    assign periph_clock_enable = ~asleep;
    // [R1] Oscillator defaults on power-on.
    assign osc_default_force = reset_cold;
    // The mode code is passed out unchanged for the clock block.
    assign operating_mode = mode_reg;
endmodule

/* File: rpm_manager_sva.sv */
`timescale 1ns/10ps
// ========
// Reset tree and mode checker.
module rpm_manager_sva import rpm_pkg::*; (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic por_src,
    input wire logic reset_pin,
    input wire logic cpu_halt,
    input wire logic wake_request,
    input wire logic reset_cold,
    input wire logic reset_system,
    input wire logic reset_pconf,
    input wire logic reset_sleep,
    input wire logic cpu_run,
    input wire logic periph_clock_enable,
    input wire logic osc_default_force,
    input wire logic [1:0] operating_mode
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);
    // The output stage may add one flop, so a window of two edges is allowed.
    property p_cold_src;
        por_src || reset_pin |-> ##[1:2] reset_cold;
    endproperty
    a_cold_src: assert property (p_cold_src) else $error("cold reset missed");
    property p_cold_only;
        !(por_src || reset_pin) [*3] |=> !reset_cold;
    endproperty
    a_cold_only: assert property (p_cold_only) else $error("stray cold reset");
    property p_cold_all;
        reset_cold |-> reset_system && reset_pconf && reset_sleep;
    endproperty
    a_cold_all: assert property (p_cold_all) else $error("cold not spread");
    property p_pconf_sys;
        reset_pconf |-> reset_system;
    endproperty
    a_pconf_sys: assert property (p_pconf_sys) else $error("pconf without system");
    property p_sleep_rst;
        operating_mode == rpm_mode_sleep [*2] |-> reset_sleep;
    endproperty
    a_sleep_rst: assert property (p_sleep_rst) else $error("sleep reset low");
    property p_sleep_stop;
        operating_mode == rpm_mode_sleep |-> !cpu_run && !periph_clock_enable;
    endproperty
    a_sleep_stop: assert property (p_sleep_stop) else $error("clocks run in sleep");
    property p_halt;
        cpu_halt && !wake_request && !reset_system && !por_src && !reset_pin
            && operating_mode == rpm_mode_active |=> operating_mode == rpm_mode_standby;
    endproperty
    a_halt: assert property (p_halt) else $error("halt ignored");
    property p_active;
        operating_mode == rpm_mode_active && !reset_system |-> cpu_run && periph_clock_enable;
    endproperty
    a_active: assert property (p_active) else $error("active mode stalled");
    property p_osc;
        osc_default_force == reset_cold && !(reset_cold && cpu_run);
    endproperty
    a_osc: assert property (p_osc) else $error("start-up state wrong");
endmodule

bind rpm_manager rpm_manager_sva u_sva (.ref_clk(ref_clk), .rst(rst), .por_src(por_src),
    .reset_pin(reset_pin), .cpu_halt(cpu_halt), .wake_request(wake_request),
    .reset_cold(reset_cold), .reset_system(reset_system), .reset_pconf(reset_pconf),
    .reset_sleep(reset_sleep), .cpu_run(cpu_run), .periph_clock_enable(periph_clock_enable),
    .osc_default_force(osc_default_force), .operating_mode(operating_mode));

/* File: rpm_tick_model.sv */
`timescale 1ns/10ps
// ========
// Prescaler model: one tick every fourth cycle while asked for.
module rpm_tick_model (
    input wire logic ref_clk,
    input wire logic tick_req,
    output logic wdog_tick,
    output int ticks
);
    logic [1:0] gap_reg = 2'b00;
    initial wdog_tick = 1'b0;
    initial ticks = 0;
    always @(posedge ref_clk) begin
        gap_reg <= gap_reg + 2'b01;
        wdog_tick <= tick_req && gap_reg == 2'b11;
        if (tick_req && gap_reg == 2'b11) ticks <= ticks + 1;
    end
endmodule

/* File: testbench.sv */
`timescale 1ns/10ps
`include "rpm_defs.svh"
module testbench import rpm_pkg::*; ;
    localparam logic [11:0] ctl = `RPM_OFS_SYS_CTRL;
    localparam logic [11:0] cau = `RPM_OFS_RESET_CAUSE;
    localparam logic [11:0] wdr = `RPM_OFS_WDOG;
    logic ref_clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rdata;
    logic pready, pslverr, err_q, wdog_tick;
    logic cpu_halt = 1'b0, wake_request = 1'b0, tick_req = 1'b0;
    logic reset_cold, reset_system, reset_pconf, reset_sleep, cpu_run, pclk_en, osc;
    logic [1:0] operating_mode;
    // Sources: power-on, pin, port combination, bus fault.
    logic [3:0] srcs = 4'h0, seen = 4'h0;
    int mismatches = 0, samples_checked = 0, ticks, ctrl_m = 0, wd_m = 0, n, d;
    integer seed = 32'h2972;

    always #10 ref_clk = ~ref_clk;
    // Short reset pulses are collected here between edges.
    always @(negedge ref_clk) seen = seen | {reset_system, reset_pconf, reset_sleep, reset_cold};

    rpm_manager DUT (.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .por_src(srcs[0]), .reset_pin(srcs[1]),
        .port_combination_reset(srcs[2]), .cpu_bus_fault(srcs[3]), .wdog_tick(wdog_tick),
        .cpu_halt(cpu_halt), .wake_request(wake_request), .reset_cold(reset_cold),
        .reset_system(reset_system), .reset_pconf(reset_pconf), .reset_sleep(reset_sleep),
        .cpu_run(cpu_run), .periph_clock_enable(pclk_en), .osc_default_force(osc),
        .operating_mode(operating_mode));
    rpm_tick_model u_tick (.ref_clk(ref_clk), .tick_req(tick_req), .wdog_tick(wdog_tick),
        .ticks(ticks));

    // ========
    // Checking and bus tasks.
    task automatic results();
        if (mismatches == 0 && samples_checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: register %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_sig(input logic [3:0] got, input logic [3:0] exp);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: signals %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] v);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= v;
        @(posedge ref_clk);
        penable <= 1'b1;
        @(posedge ref_clk);
        while (pready !== 1'b1) begin
            @(posedge ref_clk);
        end
        rdata = prdata;
        err_q = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        chk_reg(rdata, exp);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] v);
        apb(1'b1, a, v);
    endtask
    // A source is held two edges so either output pipeline depth sees it.
    task automatic fire(input int k, input logic [3:0] exp);
        seen = 4'h0;
        srcs[k] <= 1'b1;
        repeat (2) @(posedge ref_clk);
        srcs <= 4'h0;
        repeat (5) @(posedge ref_clk);
        chk_sig(seen, exp);
    endtask
    task automatic tick(input int k);
        n = ticks + k;
        tick_req <= 1'b1;
        while (ticks < n) @(posedge ref_clk);
        tick_req <= 1'b0;
        repeat (3) @(posedge ref_clk);
        wd_m = (wd_m + k) % 8;
    endtask
    task automatic mode_is(input logic [1:0] exp);
        #1;
        chk_sig({2'b00, operating_mode}, {2'b00, exp});
        chk_sig({2'b00, cpu_run, pclk_en},
            {2'b00, exp == rpm_mode_active, exp != rpm_mode_sleep});
        @(posedge ref_clk);
    endtask

    // ========
    // Main sequence.
    initial begin
        repeat (5) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        rd(ctl, 0);
        rd(cau, 0);
        rd(wdr, 0);
        rd(12'h010, 0);
        chk_sig({3'b000, err_q}, 4'h1);
        for (int i = 0; i < 4; i++) begin
            d = $random(seed);
            wr(ctl, d);
            ctrl_m = (d & 'hF0) | (ctrl_m & 'h10);
            rd(ctl, ctrl_m);
        end
        wr(ctl, 'h10);
        wr(ctl, 0);
        rd(ctl, 'h10);
        tick(1 + ($random(seed) & 3));
        rd(wdr, wd_m);
        wr(wdr, 'h0A);
        wr(wdr, 'h03);
        wd_m = 0;
        rd(wdr, 0);
        tick(2);
        wr(wdr, 'h0A);
        wr(wdr, 'h05);
        wr(wdr, 'h03);
        rd(wdr, wd_m);
        seen = 4'h0;
        tick(8 - wd_m);
        chk_sig(seen, 4'b1000);
        rd(wdr, wd_m);
        rd(cau, 'h10);
        rd(cau, 0);
        fire(3, 4'b0000);
        wr(ctl, 'h30);
        fire(3, 4'b1000);
        rd(cau, 'h20);
        wr(ctl, 'h70);
        fire(2, 4'b1100);
        rd(cau, 'h08);
        cpu_halt <= 1'b1;
        @(posedge ref_clk);
        cpu_halt <= 1'b0;
        mode_is(rpm_mode_standby);
        wake_request <= 1'b1;
        @(posedge ref_clk);
        wake_request <= 1'b0;
        mode_is(rpm_mode_active);
        wr(cau, 'h80);
        mode_is(rpm_mode_active);
        wr(ctl, 'hF0);
        wr(cau, 'h80);
        @(posedge ref_clk);
        mode_is(rpm_mode_sleep);
        fire(3, 4'b0010);
        mode_is(rpm_mode_sleep);
        fire(2, 4'b1110);
        mode_is(rpm_mode_active);
        rd(ctl, 'hF0);
        rd(12'h00C, 1);
        rd(cau, 'h08);
        wr(cau, 'h80);
        fire(1, 4'b1111);
        rd(ctl, 0);
        rd(cau, 'h06);
        wr(ctl, 'h20);
        fire(3, 4'b1000);
        fire(0, 4'b1111);
        rd(cau, 0);
        results();
    end

    initial begin
        repeat (20000) @(posedge ref_clk);
        mismatches++;
        results();
    end
endmodule
